// [core/scg_pkg.sv]
// Shared constants and types for the secure counter command gate
package scg_pkg;

   // ----------------------------------------------------------------
   // Register map (AXI4-Lite byte offsets)
   // ----------------------------------------------------------------
   localparam int unsigned SCG_AXI_AW = 4;
   localparam logic [3:0] SCG_OFF_STATREG = 4'h0;
   localparam logic [3:0] SCG_OFF_STATE = 4'h4;
   localparam logic [3:0] SCG_OFF_IRQ_STAT = 4'h8;
   localparam logic [3:0] SCG_OFF_IRQ_MASK = 4'hc;
   localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
   localparam logic [1:0] SCG_RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // Flash status register layout and delivery value
   // ----------------------------------------------------------------
   localparam int unsigned SCG_SR_W = 24;
   localparam logic [23:0] SCG_STATREG_RST = 24'h200200;
   localparam int unsigned SCG_BIT_WRITE_IN_PROGRESS = 0;
   localparam int unsigned SCG_BIT_WEL = 1;
   localparam int unsigned SCG_BIT_QUAD_ENABLE = 9;
   localparam int unsigned SCG_BIT_SUS = 15;
   localparam int unsigned SCG_BIT_DRIVE_STRENGTH0 = 21;
   localparam logic [23:0] SCG_SR_LIVE_MASK = 24'h008003;

   // ----------------------------------------------------------------
   // Extended status values
   // ----------------------------------------------------------------
   localparam logic [7:0] SCG_EXT_POWERON = 8'h00;
   localparam logic [7:0] SCG_EXT_OK = 8'h80;
   localparam logic [7:0] SCG_EXT_BUSY = 8'h01;
   localparam int unsigned SCG_ERR_W = 6;

   // ----------------------------------------------------------------
   // Serial framing and interrupt layout
   // ----------------------------------------------------------------
   localparam logic [4:0] SCG_BITS_OPCODE = 5'h08;
   localparam logic [4:0] SCG_BITS_DUMMY_END = 5'h10;
   localparam int unsigned SCG_IRQ_W = 4;
   localparam int unsigned SCG_IRQ_CNT_DONE = 0;
   localparam int unsigned SCG_IRQ_PE_DONE = 1;
   localparam int unsigned SCG_IRQ_REFUSED = 2;
   localparam int unsigned SCG_IRQ_SUSPENDED = 3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCG_PE_IDLE = 3'b001,
      SCG_PE_RUN = 3'b010,
      SCG_PE_SUSP = 3'b100
   } scg_pe_t;

   typedef enum logic [3:0] {
      SCG_C_OTHER, SCG_C_READ, SCG_C_WRITE, SCG_C_CHIPERASE, SCG_C_WRSR,
      SCG_C_RDSR, SCG_C_WRITE_ENABLE, SCG_C_SUSPEND, SCG_C_RESUME, SCG_C_DPD,
      SCG_C_RELDPD, SCG_C_CNT, SCG_C_CNTRB
   } scg_cls_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } scg_link_t;

   typedef struct packed {
      logic valid;
      logic [7:0] op;
   } scg_disp_t;

endpackage

// [core/scg_gate.sv]
// Command admission and state gating for the secure counter command pair
//
// Summary of operation
// - Deep power-down ignores counter and readback commands.
// - Counter command runs regardless of write enable.
// - Counter state from opcode until extended busy clears.
// - Suspend during counter state is discarded.
// - Program/erase state until status busy clears.
// - Suspended state begins when suspend-done sets.
// - Suspend moves to suspended, except chip erase/status write.
// - Counter command accepted during program/erase or suspend.
// - Readback in counter state reports busy or done.
// - Readback in other states returns last counter status.
// - Status read accepted outside deep power-down, busy excludes counter.
// - Status register delivers 00H with S21, S9 set.
// - Array reads served while program/erase suspended.
// - Extended bit 0 set while counter command executes.
// - Extended status 80H on success, 00H after power-up.
`timescale 1ns/10ps
module scg_gate #(
   parameter logic [7:0] OP_READ = 8'h10,
   parameter logic [7:0] OP_PROG = 8'h11,
   parameter logic [7:0] OP_ERASE = 8'h12,
   parameter logic [7:0] OP_CHIP_ERASE = 8'h13,
   parameter logic [7:0] OP_WRSR = 8'h14,
   parameter logic [7:0] OP_RDSR = 8'h15,
   parameter logic [7:0] OP_WRITE_ENABLE = 8'h16,
   parameter logic [7:0] OP_SUSPEND = 8'h17,
   parameter logic [7:0] OP_RESUME = 8'h18,
   parameter logic [7:0] OP_DPD = 8'h19,
   parameter logic [7:0] OP_RELDPD = 8'h1a,
   parameter logic [7:0] OP_CNT = 8'h1b,
   parameter logic [7:0] OP_CNTRB = 8'h1c
) (
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire scg_pkg::scg_link_t LINK_I,
   output logic SO_O,
   output logic SO_OE_O,
   input wire logic PE_DONE_I,
   input wire logic SUSP_DONE_I,
   input wire logic CNT_DONE_I,
   input wire logic [scg_pkg::SCG_ERR_W-1:0] CNT_ERR_I,
   output scg_pkg::scg_disp_t DISP_O,
   output logic IRQ_O,
   input wire logic [scg_pkg::SCG_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [scg_pkg::SCG_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import scg_pkg::*;

   // Clashing opcodes would make the decode ambiguous
   if (OP_CNT == OP_CNTRB || OP_SUSPEND == OP_RESUME || OP_READ == OP_RDSR) begin : g_op_clash
      $error("scg_gate: opcode parameters must be distinct");
   end

   // ----------------------------------------------------------------
   // Opcode classification
   // ----------------------------------------------------------------
   function automatic scg_cls_t classify(input logic [7:0] op);
      scg_cls_t c;
      c = SCG_C_OTHER;
      case (op)
         OP_READ: c = SCG_C_READ;
         OP_PROG: c = SCG_C_WRITE;
         OP_ERASE: c = SCG_C_WRITE;
         OP_CHIP_ERASE: c = SCG_C_CHIPERASE;
         OP_WRSR: c = SCG_C_WRSR;
         OP_RDSR: c = SCG_C_RDSR;
         OP_WRITE_ENABLE: c = SCG_C_WRITE_ENABLE;
         OP_SUSPEND: c = SCG_C_SUSPEND;
         OP_RESUME: c = SCG_C_RESUME;
         OP_DPD: c = SCG_C_DPD;
         OP_RELDPD: c = SCG_C_RELDPD;
         OP_CNT: c = SCG_C_CNT;
         OP_CNTRB: c = SCG_C_CNTRB;
         default: c = SCG_C_OTHER;
      endcase
      return c;
   endfunction

   function automatic logic [31:0] word_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Link sampling: two flops, then an edge stage that reads stage two
   // ----------------------------------------------------------------
   scg_link_t l1_q, l2_q, l3_q;
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         l1_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
         l2_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
         l3_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
      end else begin
         l1_q <= LINK_I;
         l2_q <= l1_q;
         l3_q <= l2_q;
      end
   end

   wire sel = !l2_q.cs_n;
   wire rise = sel && l2_q.sclk && !l3_q.sclk;
   wire fall = sel && !l2_q.sclk && l3_q.sclk;

   // ----------------------------------------------------------------
   // Frame shifter and opcode capture
   // ----------------------------------------------------------------
   logic [4:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic tx_on_q;
   logic so_q, so_oe_q;
   wire [7:0] rx_next = {rx_q[6:0], l2_q.si};
   wire [4:0] bit_next = (bit_cnt_q == 5'h1f) ? bit_cnt_q : bit_cnt_q + 5'h01;
   wire op_done = rise && (bit_next == SCG_BITS_OPCODE);
   wire dummy_done = rise && (bit_next == SCG_BITS_DUMMY_END);
   wire scg_cls_t cls = classify(rx_next);

   // ----------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------
   scg_pe_t pe_q;
   logic cnt_busy_q, dpd_q, wel_q, no_susp_q, susp_pend_q, sus_bit_q, rb_frame_q;
   logic [7:0] ext_q;
   logic [SCG_SR_W-1:0] sr_cfg_q;

   // Admission decision for the opcode seen this cycle
   logic accept, refuse;
   always_comb begin
      accept = 1'b0;
      if (dpd_q) begin
         accept = (cls == SCG_C_RELDPD);
      end else begin
         case (cls)
            SCG_C_READ: accept = (pe_q != SCG_PE_RUN);
            SCG_C_WRITE, SCG_C_CHIPERASE, SCG_C_WRSR:
               accept = wel_q && (pe_q == SCG_PE_IDLE);
            SCG_C_RDSR: accept = 1'b1;
            SCG_C_WRITE_ENABLE: accept = 1'b1;
            SCG_C_SUSPEND:
               accept = !cnt_busy_q && (pe_q == SCG_PE_RUN) && !no_susp_q
                        && !susp_pend_q;
            SCG_C_RESUME: accept = !cnt_busy_q && (pe_q == SCG_PE_SUSP);
            SCG_C_DPD: accept = (pe_q == SCG_PE_IDLE) && !cnt_busy_q;
            SCG_C_CNT: accept = !cnt_busy_q;
            SCG_C_CNTRB: accept = 1'b1;
            default: accept = 1'b0;
         endcase
      end
      refuse = !accept;
   end

   wire take = op_done && accept;
   wire drop = op_done && refuse;
   wire [SCG_SR_W-1:0] sr_live = (sr_cfg_q & ~SCG_SR_LIVE_MASK)
                                 | (SCG_SR_W'(pe_q != SCG_PE_IDLE)
                                    << SCG_BIT_WRITE_IN_PROGRESS)
                                 | (SCG_SR_W'(wel_q) << SCG_BIT_WEL)
                                 | (SCG_SR_W'(sus_bit_q) << SCG_BIT_SUS);

   // Serial shifter: status byte goes out after the opcode, extended
   // status after the dummy byte of a readback frame
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I || !sel) begin
         bit_cnt_q <= 5'h00;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         tx_on_q <= 1'b0;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
         rb_frame_q <= 1'b0;
      end else begin
         if (rise) begin
            bit_cnt_q <= bit_next;
            rx_q <= rx_next;
         end
         if (take && cls == SCG_C_RDSR) begin
            tx_q <= sr_live[7:0];
            tx_on_q <= 1'b1;
         end else if (take && cls == SCG_C_CNTRB) begin
            rb_frame_q <= 1'b1;
         end else if (dummy_done && rb_frame_q) begin
            tx_q <= ext_q;
            tx_on_q <= 1'b1;
         end else if (fall && tx_on_q) begin
            so_q <= tx_q[7];
            so_oe_q <= 1'b1;
            tx_q <= {tx_q[6:0], tx_q[7]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Program/erase state machine
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         pe_q <= SCG_PE_IDLE;
         no_susp_q <= 1'b0;
         susp_pend_q <= 1'b0;
         sus_bit_q <= 1'b0;
      end else begin
         case (pe_q)
            SCG_PE_IDLE: begin
               if (take && (cls == SCG_C_WRITE || cls == SCG_C_CHIPERASE
                            || cls == SCG_C_WRSR)) begin
                  pe_q <= SCG_PE_RUN;
                  no_susp_q <= (cls != SCG_C_WRITE);
               end
            end
            SCG_PE_RUN: begin
               if (take && cls == SCG_C_SUSPEND) begin
                  susp_pend_q <= 1'b1;
               end
               if (PE_DONE_I) begin
                  pe_q <= SCG_PE_IDLE;
                  susp_pend_q <= 1'b0;
               end else if (SUSP_DONE_I && susp_pend_q) begin
                  pe_q <= SCG_PE_SUSP;
                  sus_bit_q <= 1'b1;
                  susp_pend_q <= 1'b0;
               end
            end
            SCG_PE_SUSP: begin
               if (take && cls == SCG_C_RESUME) begin
                  pe_q <= SCG_PE_RUN;
                  sus_bit_q <= 1'b0;
               end
            end
            default: pe_q <= SCG_PE_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Counter state, extended status, power-down and write enable
   // ----------------------------------------------------------------
   wire [7:0] ext_done = (CNT_ERR_I == '0) ? SCG_EXT_OK : {1'b0, CNT_ERR_I, 1'b0};
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         cnt_busy_q <= 1'b0;
         ext_q <= SCG_EXT_POWERON;
         dpd_q <= 1'b0;
         wel_q <= 1'b0;
      end else begin
         if (take && cls == SCG_C_CNT) begin
            cnt_busy_q <= 1'b1;
            ext_q <= SCG_EXT_BUSY;
         end else if (cnt_busy_q && CNT_DONE_I) begin
            cnt_busy_q <= 1'b0;
            ext_q <= ext_done;
         end
         if (take && cls == SCG_C_DPD) begin
            dpd_q <= 1'b1;
         end else if (take && cls == SCG_C_RELDPD) begin
            dpd_q <= 1'b0;
         end
         if (take && cls == SCG_C_WRITE_ENABLE) begin
            wel_q <= 1'b1;
         end else if (take && (cls == SCG_C_WRITE || cls == SCG_C_CHIPERASE
                               || cls == SCG_C_WRSR)) begin
            wel_q <= 1'b0;
         end
      end
   end

   // Accepted opcodes are handed to the engines as a one-cycle pulse
   scg_disp_t disp_q;
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         disp_q <= '{valid: 1'b0, op: 8'h00};
      end else begin
         disp_q <= '{valid: take, op: rx_next};
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_got_q, w_got_q;
   logic [SCG_AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [SCG_IRQ_W-1:0] irq_stat_q, irq_mask_q;
   logic irq_q;

   wire aw_hs = S_AXI_AWVALID && awready_q;
   wire w_hs = S_AXI_WVALID && wready_q;
   wire ar_hs = S_AXI_ARVALID && arready_q;
   wire wr_go = aw_got_q && w_got_q && !bvalid_q;
   wire wr_ok = (awaddr_q == SCG_OFF_STATREG) || (awaddr_q == SCG_OFF_IRQ_MASK);
   wire rd_stat = ar_hs && (S_AXI_ARADDR == SCG_OFF_IRQ_STAT);
   wire [31:0] state_word = {17'h00000, wel_q, dpd_q, cnt_busy_q, 1'b0, pe_q, ext_q};
   wire [31:0] sr_word = {8'h00, sr_live};
   wire [31:0] merged = word_merge({8'h00, sr_cfg_q}, wdata_q, wstrb_q);
   wire [31:0] mask_merged = word_merge({28'h0000000, irq_mask_q}, wdata_q, wstrb_q);
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         SCG_OFF_STATREG: rd_mux = sr_word;
         SCG_OFF_STATE: rd_mux = state_word;
         SCG_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
         SCG_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= SCG_RESP_OKAY;
         sr_cfg_q <= SCG_STATREG_RST;
         irq_mask_q <= '0;
      end else begin
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
            awready_q <= 1'b0;
         end
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
            wready_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? SCG_RESP_OKAY : SCG_RESP_DECERR;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            if (awaddr_q == SCG_OFF_STATREG) begin
               sr_cfg_q <= merged[SCG_SR_W-1:0];
            end
            if (awaddr_q == SCG_OFF_IRQ_MASK) begin
               irq_mask_q <= mask_merged[SCG_IRQ_W-1:0];
            end
         end
         if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Read path; a status read clears the sticky bits it returned
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= SCG_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? SCG_RESP_OKAY : SCG_RESP_DECERR;
         end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: a new event wins over the read that clears it
   // ----------------------------------------------------------------
   wire [SCG_IRQ_W-1:0] ev;
   assign ev[SCG_IRQ_CNT_DONE] = cnt_busy_q && CNT_DONE_I;
   assign ev[SCG_IRQ_PE_DONE] = (pe_q == SCG_PE_RUN) && PE_DONE_I;
   assign ev[SCG_IRQ_REFUSED] = drop;
   assign ev[SCG_IRQ_SUSPENDED] = (pe_q == SCG_PE_RUN) && !PE_DONE_I && SUSP_DONE_I
                                  && susp_pend_q;
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= (rd_stat ? '0 : irq_stat_q) | ev;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign SO_O = so_q;
   assign SO_OE_O = so_oe_q;
   assign DISP_O = disp_q;
   assign IRQ_O = irq_q;
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

endmodule

// [testbench/scg_gate_checker.sv]
// Assertion checker for the secure counter command gate
`timescale 1ns/10ps
module scg_gate_checker #(
   parameter logic [7:0] OP_READ = 8'h10, OP_PROG = 8'h11, OP_ERASE = 8'h12,
   parameter logic [7:0] OP_CHIP_ERASE = 8'h13, OP_WRSR = 8'h14, OP_SUSPEND = 8'h17,
   parameter logic [7:0] OP_RESUME = 8'h18, OP_DPD = 8'h19, OP_RELDPD = 8'h1a,
   parameter logic [7:0] OP_CNT = 8'h1b, OP_CNTRB = 8'h1c
) (
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic PE_DONE_I,
   input wire logic SUSP_DONE_I,
   input wire logic CNT_DONE_I,
   input wire scg_pkg::scg_disp_t DISP_O
);
   import scg_pkg::*;
   // ---------------------------------------------
   // Shadow state rebuilt from dispatched opcodes
   // ---------------------------------------------
   logic cb_q, pe_q, su_q, ce_q, dp_q;
   wire v = DISP_O.valid;
   wire [7:0] op = DISP_O.op;
   wire ce_op = v && (op == OP_CHIP_ERASE || op == OP_WRSR);
   wire pe_op = ce_op || (v && (op == OP_PROG || op == OP_ERASE));
   wire rs_op = v && op == OP_RESUME;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         {cb_q, pe_q, su_q, ce_q, dp_q} <= '0;
      end else begin
         cb_q <= (v && op == OP_CNT) | (cb_q & ~CNT_DONE_I);
         pe_q <= pe_op | (pe_q & ~PE_DONE_I);
         ce_q <= ce_op | (ce_q & ~PE_DONE_I);
         su_q <= (SUSP_DONE_I & pe_q & ~PE_DONE_I) | (su_q & ~PE_DONE_I & ~rs_op);
         dp_q <= (v && op == OP_DPD) | (dp_q & ~(v && op == OP_RELDPD));
      end
   end
   property p_cnt; v && op == OP_CNT |-> !cb_q; endproperty
   a_cnt: assert property (p_cnt) else $error("counter taken while busy");
   property p_sus_c; v && op == OP_SUSPEND |-> !cb_q; endproperty
   a_sus_c: assert property (p_sus_c) else $error("suspend taken in counter");
   property p_sus_s; v && op == OP_SUSPEND |-> !su_q && !ce_q; endproperty
   a_sus_s: assert property (p_sus_s) else $error("suspend wrongly taken");
   property p_rs_c; rs_op |-> !cb_q; endproperty
   a_rs_c: assert property (p_rs_c) else $error("resume taken in counter");
   property p_rs_r; rs_op |-> su_q; endproperty
   a_rs_r: assert property (p_rs_r) else $error("resume taken outside suspend");
   property p_rd; v && op == OP_READ |-> !pe_q || su_q; endproperty
   a_rd: assert property (p_rd) else $error("read taken in program");
   property p_wr; pe_op |-> !pe_q; endproperty
   a_wr: assert property (p_wr) else $error("write taken in program");
   property p_dp; dp_q |-> !(v && (op == OP_CNT || op == OP_CNTRB)); endproperty
   a_dp: assert property (p_dp) else $error("counter op taken in power-down");
   cover property (SUSP_DONE_I && pe_q);
   cover property (rs_op);
   cover property (cb_q && CNT_DONE_I);
endmodule

// [testbench/scg_host_model.sv]
// Serial host model that frames opcodes on the link
`timescale 1ns/10ps
module scg_host_model (
   output scg_pkg::scg_link_t link_o,
   input wire logic so_i
);
   import scg_pkg::*;
   initial link_o = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
   // Link clock stands low between frames; half period 80 ns
   task automatic frame(input logic [7:0] op, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      #37 link_o.cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         link_o.si = (i < 8) ? op[7 - i] : 1'b0;
         #80 link_o.sclk = 1'b1;
         // Sample late in the high phase, the output moves after a synced fall
         #79 if (i >= 8) rx = {rx[6:0], so_i};
         #1 link_o.sclk = 1'b0;
      end
      #40 link_o.cs_n = 1'b1;
      link_o.si = ~link_o.si;
      #200;
   endtask
endmodule

// [testbench/scg_gate_bench.sv]
// Self-checking bench for the secure counter command gate
`timescale 1ns/10ps
module scg_gate_bench;
   import scg_pkg::*;
   // Opcodes match the gate's default parameters
   localparam logic [7:0] RD = 8'h10, PG = 8'h11, CE = 8'h13, SR = 8'h15, WE = 8'h16;
   localparam logic [7:0] SU = 8'h17, RS = 8'h18, DP = 8'h19, RL = 8'h1a, CN = 8'h1b, CB = 8'h1c;
   logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic so, oe, irq, awr, wrd, bv, arr, rv;
   logic [2:0] ev = 3'h0;
   logic [5:0] err = 6'h00;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rdat, v;
   logic [1:0] br, rr, r;
   logic [7:0] rx, lop;
   scg_link_t link;
   scg_disp_t disp;
   int n_fail = 0, checks_done = 0, nd = 0, n0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (disp.valid === 1'b1) begin
         nd++;
         lop = disp.op;
      end
   end
   scg_gate scg_gate_i (
      .CLK_SYS_I(clk), .RESETN_I(rstn), .LINK_I(link), .SO_O(so), .SO_OE_O(oe),
      .PE_DONE_I(ev[2]), .SUSP_DONE_I(ev[1]), .CNT_DONE_I(ev[0]), .CNT_ERR_I(err),
      .DISP_O(disp), .IRQ_O(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
   // Released output shows the inverse, so a missing enable corrupts the sample
   scg_host_model scg_host_model_i (.link_o(link), .so_i(oe ? so : ~so));
   // -------------------------
   // Shared tasks
   // -------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (bv !== 1'b1);
      r = br;
      bry <= 1'b0;
   endtask
   task axr(input logic [3:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      v = rdat;
      r = rr;
      rry <= 1'b0;
   endtask
   task snd(input logic [7:0] op, input int nb, input logic acc);
      n0 = nd;
      scg_host_model_i.frame(op, nb, rx);
      chk("dispatch", {31'h0, acc}, 32'(nd - n0));
      if (acc) chk("opcode", {24'h0, op}, {24'h0, lop});
      chk("oe_idle", 32'h0, {31'h0, oe});
   endtask
   task pulse(input logic [2:0] k);
      @(posedge clk);
      ev <= k;
      @(posedge clk);
      ev <= 3'h0;
   endtask
   // -------------------------
   // Scenarios
   // -------------------------
   task t_boot;
      axr(SCG_OFF_STATREG);
      chk("statreg", 32'h0020_0200, v);
      chk("rresp", {30'h0, SCG_RESP_OKAY}, {30'h0, r});
      axr(SCG_OFF_STATE);
      chk("state", 32'h0000_0100, v);
      axr(4'h2);
      chk("rresp", {30'h0, SCG_RESP_DECERR}, {30'h0, r});
      chk("rdata", 32'h0, v);
      snd(CB, 24, 1'b1);
      chk("ext", 32'h00, {24'h0, rx});
   endtask
   task t_cnt;
      axw(SCG_OFF_IRQ_MASK, 32'h1);
      chk("wresp", {30'h0, SCG_RESP_OKAY}, {30'h0, r});
      snd(CN, 8, 1'b1);
      snd(CB, 24, 1'b1);
      chk("ext", 32'h01, {24'h0, rx});
      snd(SU, 8, 1'b0);
      snd(CN, 8, 1'b0);
      snd(SR, 16, 1'b1);
      chk("status", 32'h00, {24'h0, rx});
      pulse(3'b001);
      snd(CB, 24, 1'b1);
      chk("ext", 32'h80, {24'h0, rx});
      chk("irq", 32'h1, {31'h0, irq});
      axr(SCG_OFF_IRQ_STAT);
      chk("irq_stat", 32'h5, v);
      axw(SCG_OFF_IRQ_STAT, 32'h0);
      chk("ro_write", {30'h0, SCG_RESP_DECERR}, {30'h0, r});
      chk("irq", 32'h0, {31'h0, irq});
   endtask
   task t_pe;
      snd(WE, 8, 1'b1);
      snd(PG, 8, 1'b1);
      snd(RD, 8, 1'b0);
      snd(SR, 16, 1'b1);
      chk("write_in_progress", 32'h1, {31'h0, rx[0]});
      snd(CB, 24, 1'b1);
      chk("ext", 32'h80, {24'h0, rx});
      snd(SU, 8, 1'b1);
      pulse(3'b010);
      axr(SCG_OFF_STATE);
      chk("pe", 32'h4, {29'h0, v[10:8]});
      snd(RD, 8, 1'b1);
      snd(SU, 8, 1'b0);
      // Discouraged for hosts, yet the gate must still take it
      snd(CN, 8, 1'b1);
      snd(RS, 8, 1'b0);
      pulse(3'b001);
      snd(RS, 8, 1'b1);
      snd(RS, 8, 1'b0);
      axr(SCG_OFF_STATE);
      chk("pe", 32'h2, {29'h0, v[10:8]});
      pulse(3'b100);
      axr(SCG_OFF_STATE);
      chk("pe", 32'h1, {29'h0, v[10:8]});
   endtask
   task t_ce;
      snd(WE, 8, 1'b1);
      snd(CE, 8, 1'b1);
      snd(SU, 8, 1'b0);
      pulse(3'b100);
   endtask
   task t_dpd;
      axr(SCG_OFF_IRQ_STAT);
      snd(DP, 8, 1'b1);
      snd(CN, 8, 1'b0);
      snd(CB, 24, 1'b0);
      chk("irq", 32'h0, {31'h0, irq});
      snd(RL, 8, 1'b1);
      snd(CB, 24, 1'b1);
      chk("ext", 32'h80, {24'h0, rx});
      // A failed counter command reports its error bits instead of success
      @(posedge clk);
      err <= 6'h04;
      snd(CN, 8, 1'b1);
      pulse(3'b001);
      snd(CB, 24, 1'b1);
      chk("ext_err", 32'h08, {24'h0, rx});
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_boot;
      t_cnt;
      t_pe;
      t_ce;
      t_dpd;
      close_out;
   end
   initial begin
      #1500000;
      n_fail++;
      close_out;
   end
endmodule
bind scg_gate scg_gate_checker scg_gate_checker_i (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
   .PE_DONE_I(PE_DONE_I), .SUSP_DONE_I(SUSP_DONE_I), .CNT_DONE_I(CNT_DONE_I), .DISP_O(DISP_O));
